// ---- verilog/core_debug_control_unit.sv ----
// core debug control unit: register maps, debug_ctl_stat, entry redirection, jtag access
// Behaviour
// - halt configuration uses the reset vector for debug and the debug mode code 0x15.
// - a debug exception in halt configuration enters debug mode through the reset vector.
// - in monitor configuration it enters abort mode via prefetch- or data-abort vector by cause.
// - debug register accesses need zero opcode fields and user-mode access is undefined.
// - system coprocessor register 14 selects breakpoints by secondary number 8,9,0,3,4.
// - debug coprocessor primary numbers 8 to 14 select tx, rx, status, trace, checkpoints, link.
// - debug coprocessor takes transfers and load/store, data operations trap as undefined.
// - the debugger reaches tx, rx and selected link and status bits over jtag.
// - a vector-trap bit written one enables that trap, written zero disables it.
// - global debug on is software-written, jtag read-only, cleared by processor reset only.
// - the halt selector is jtag-written, software read-only, cleared by test reset only.
// - the seven trap bits are jtag-written, software read-only, cleared by test reset only.
// - a debug handler can be loaded over jtag and locked into the instruction cache.
// - the entry cause field records the highest-priority cause of the latest debug exception.
// - the trace buffer runs only with trace enable and global debug, and entry clears enable.
// - a data abort in the special debug state is suppressed and sets sticky abort.
`timescale 1ns/1ps
module core_debug_control_unit
(
    input  wire logic                           clk,
    input  wire logic                           nrst,
    input  wire debug_unit_pkg::cp_req_type     cp_req,
    input  wire logic [31:0]                    sysctl_rdata,
    output logic                                cp_done,
    output logic                                cp_undef,
    output logic [31:0]                         cp_rdata,
    output logic [4:0]                          sysctl_sel,
    output logic                                sysctl_wr,
    output logic [31:0]                         sysctl_wdata,
    input  wire debug_unit_pkg::dbg_event_type  dbg_event,
    output debug_unit_pkg::dbg_entry_type       dbg_entry,
    output logic                                abort_suppress,
    output logic                                trace_run,
    output logic                                trace_fill_once,
    input  wire logic                           tck,
    input  wire logic                           trst_n,
    input  wire logic                           tdi,
    input  wire logic                           jtag_capture,
    input  wire logic                           jtag_shift,
    input  wire logic                           jtag_update,
    input  wire logic [1:0]                     jtag_target,
    output logic                                tdo,
    output logic                                icache_load,
    output logic                                icache_lock,
    output logic [31:0]                         icache_data
);
    import debug_unit_pkg::*;

    // ==========================================
    // pin synchronisers: stage 1 feeds stage 2 only; kept out of processor reset
    // so that a test reset still reaches halt and traps while nrst is low
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] pin_s1_reg;
    logic [NSYNC-1:0] pin_s2_reg;
    logic [NSYNC-1:0] pin_s3_reg;
    wire  [NSYNC-1:0] pin_raw = {tck, trst_n, tdi, jtag_capture, jtag_shift, jtag_update,
                                 jtag_target};
    always_ff @(posedge clk)
    begin
        pin_s1_reg <= pin_raw;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
    end
    wire             tck_rise  = pin_s2_reg[7] & ~pin_s3_reg[7];
    wire             trst_act  = ~pin_s2_reg[6];
    wire             tdi_s     = pin_s2_reg[5];
    wire             cap_rise  = pin_s2_reg[4] & ~pin_s3_reg[4];
    wire             shift_s   = pin_s2_reg[3];
    wire             upd_rise  = pin_s2_reg[2] & ~pin_s3_reg[2];
    jtag_target_type tgt;
    assign tgt = jtag_target_type'(pin_s2_reg[1:0]);

    // ==========================================
    // state
    logic        ge_reg, sa_reg, tmode_reg, ten_reg;
    logic [2:0]  cause_reg;
    logic        halt_reg;
    logic [6:0]  traps_reg;
    logic [31:0] tx_reg, rx_reg, chk0_reg, chk1_reg, jshift_reg;
    logic        tx_full_reg, rx_full_reg, boot_reg;

    // image of debug_ctl_stat; reserved bits read zero
    wire [31:0] dcs_img = {ge_reg, halt_reg, 6'h00, traps_reg[6], traps_reg[5], 1'b0,
                           traps_reg[4:0], 10'h000, sa_reg, cause_reg, tmode_reg, ten_reg};
    wire [31:0] link_img = ({31'h0, rx_full_reg} << LINK_RXF) |
                           ({31'h0, tx_full_reg} << LINK_TXF);

    // ==========================================
    // coprocessor decode
    function automatic logic [4:0] bkpt_onehot(input logic [3:0] secondary_reg_num);
        bkpt_onehot = {secondary_reg_num == CRM_DBKCTL, secondary_reg_num == CRM_DBKPT1, secondary_reg_num == CRM_DBKPT0,
                       secondary_reg_num == CRM_IBKPT1, secondary_reg_num == CRM_IBKPT0};
    endfunction

    wire is_dbg    = cp_req.valid & (cp_req.copro == COPRO_DEBUG);
    wire is_sys    = cp_req.valid & (cp_req.copro == COPRO_SYSCTL) & (cp_req.primary_reg_num == CRN_BKPT);
    wire priv_ok   = (cp_req.mode != MODE_USER);
    wire ops_zero  = (cp_req.op1 == 3'h0) & (cp_req.op2 == 3'h0);
    wire to_core   = (cp_req.kind == CP_READ) | (cp_req.kind == CP_STORE);
    wire from_core = (cp_req.kind == CP_WRITE) | (cp_req.kind == CP_LOAD);
    wire bad_dbg   = is_dbg & (~priv_ok | (cp_req.kind == CP_OP));
    wire bad_sys   = is_sys & (~priv_ok | (cp_req.kind == CP_OP) | ~ops_zero);
    wire dbg_ok    = is_dbg & ~bad_dbg & ops_zero & (cp_req.secondary_reg_num == 4'h0);
    wire sys_ok    = is_sys & ~bad_sys;
    wire dbg_wr    = dbg_ok & from_core;
    wire dbg_rd    = dbg_ok & to_core;
    wire [4:0] sys_hit = bkpt_onehot(cp_req.secondary_reg_num);

    logic [31:0] dbg_rdata;
    always_comb
    begin
        case (cp_req.primary_reg_num)
            CRN_TX:   dbg_rdata = tx_reg;
            CRN_RX:   dbg_rdata = rx_reg;
            CRN_DCS:  dbg_rdata = dcs_img;
            CRN_TBUF: dbg_rdata = 32'h0;
            CRN_CHK0: dbg_rdata = chk0_reg;
            CRN_CHK1: dbg_rdata = chk1_reg;
            CRN_LINK: dbg_rdata = link_img;
            default:  dbg_rdata = 32'h0;
        endcase
    end
    wire sw_dcs = dbg_wr & (cp_req.primary_reg_num == CRN_DCS);

    // ==========================================
    // debug exception selection
    wire [6:0] vec_trap = dbg_event.vector_hit & traps_reg;
    wire boot_hit  = boot_reg & traps_reg[0];
    wire trap_hit  = (ge_reg & (|vec_trap[6:1])) | vec_trap[0];
    wire dbkpt_hit = ge_reg & dbg_event.data_bkpt;
    wire ext_hit   = ge_reg & (dbg_event.ext_break | dbg_event.trace_full);
    wire ibkpt_hit = ge_reg & dbg_event.inst_bkpt;
    wire bkpt_hit  = ge_reg & dbg_event.bkpt_instr;
    wire take      = boot_hit | trap_hit | dbkpt_hit | ext_hit | ibkpt_hit | bkpt_hit;
    // priority order follows the event ranking, reset trap first
    wire [2:0] take_cause = boot_hit  ? CAUSE_RESET :
                            trap_hit  ? CAUSE_VTRAP :
                            dbkpt_hit ? CAUSE_DBKPT :
                            dbg_event.ext_break ? (ext_hit ? CAUSE_EXT : CAUSE_IBKPT) :
                            ext_hit   ? CAUSE_TFULL :
                            ibkpt_hit ? CAUSE_IBKPT : CAUSE_BKPT;
    dbg_entry_type entry_next;
    always_comb
    begin
        entry_next.take = take;
        if (halt_reg)
        begin
            entry_next.vector = VEC_RESET;
            entry_next.mode   = MODE_DEBUG;
        end
        else
        begin
            // data breakpoints behave as data aborts, the rest as prefetch aborts
            entry_next.vector = (take_cause == CAUSE_DBKPT) ? VEC_DABORT : VEC_PABORT;
            entry_next.mode   = MODE_ABORT;
        end
        entry_next.cause = take_cause;
    end
    wire abort_in_dbg = dbg_event.data_abort & dbg_event.special_state;

    // ==========================================
    // software-owned bits, cleared by processor reset, which also sets the boot flag
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ge_reg    <= 1'b0;
            sa_reg    <= 1'b0;
            tmode_reg <= 1'b0;
            ten_reg   <= 1'b0;
            cause_reg <= CAUSE_RESET;
            boot_reg  <= 1'b1;
        end
        else
        begin
            boot_reg  <= 1'b0;
            ge_reg    <= sw_dcs ? cp_req.wdata[GE_POS] : ge_reg;
            tmode_reg <= sw_dcs ? cp_req.wdata[TMODE_POS] : tmode_reg;
            // hardware set beats a software clear in the same cycle
            sa_reg    <= abort_in_dbg | (sw_dcs ? cp_req.wdata[SA_POS] : sa_reg);
            cause_reg <= take ? take_cause :
                         sw_dcs ? cp_req.wdata[CAUSE_LSB+:3] : cause_reg;
            ten_reg   <= ~take & (sw_dcs ? cp_req.wdata[TEN_POS] : ten_reg);
        end
    end

    // ==========================================
    // jtag-owned bits: untouched by processor reset, cleared by synced test reset
    wire jt_upd_dcs = upd_rise & (tgt == JT_DCS);
    always_ff @(posedge clk)
    begin
        if (trst_act)
        begin
            halt_reg  <= 1'b0;
            traps_reg <= TRAPS_RESET;
        end
        else if (jt_upd_dcs)
        begin
            halt_reg  <= jshift_reg[HALT_POS];
            traps_reg <= {jshift_reg[23], jshift_reg[22], jshift_reg[20:16]};
        end
    end

    // ==========================================
    // jtag shift path and comm link
    logic [31:0] cap_val;
    always_comb
    begin
        case (tgt)
            JT_DCS:  cap_val = dcs_img;
            JT_TX:   cap_val = tx_reg;
            JT_RX:   cap_val = link_img;
            default: cap_val = 32'h0;
        endcase
    end
    wire sw_tx_wr = dbg_wr & (cp_req.primary_reg_num == CRN_TX);
    wire sw_rx_rd = dbg_rd & (cp_req.primary_reg_num == CRN_RX);
    wire jt_tx_rd = upd_rise & (tgt == JT_TX);
    wire jt_rx_wr = upd_rise & (tgt == JT_RX);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            jshift_reg  <= '0;
            tdo         <= 1'b0;
            tx_reg      <= '0;
            rx_reg      <= '0;
            chk0_reg    <= '0;
            chk1_reg    <= '0;
            tx_full_reg <= 1'b0;
            rx_full_reg <= 1'b0;
        end
        else
        begin
            if (cap_rise)
                jshift_reg <= cap_val;
            else if (shift_s & tck_rise)
                jshift_reg <= {tdi_s, jshift_reg[31:1]};
            tdo         <= jshift_reg[0];
            tx_reg      <= sw_tx_wr ? cp_req.wdata : tx_reg;
            rx_reg      <= jt_rx_wr ? jshift_reg : rx_reg;
            chk0_reg    <= (dbg_wr & (cp_req.primary_reg_num == CRN_CHK0)) ? cp_req.wdata : chk0_reg;
            chk1_reg    <= (dbg_wr & (cp_req.primary_reg_num == CRN_CHK1)) ? cp_req.wdata : chk1_reg;
            tx_full_reg <= sw_tx_wr | (tx_full_reg & ~jt_tx_rd);
            rx_full_reg <= jt_rx_wr | (rx_full_reg & ~sw_rx_rd);
        end
    end

    // ==========================================
    // registered outputs
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cp_done         <= 1'b0;
            cp_undef        <= 1'b0;
            cp_rdata        <= '0;
            sysctl_sel      <= '0;
            sysctl_wr       <= 1'b0;
            sysctl_wdata    <= '0;
            dbg_entry       <= '0;
            abort_suppress  <= 1'b0;
            trace_run       <= 1'b0;
            trace_fill_once <= 1'b0;
            icache_load     <= 1'b0;
            icache_lock     <= 1'b0;
            icache_data     <= '0;
        end
        else
        begin
            cp_done         <= is_dbg | is_sys;
            cp_undef        <= bad_dbg | bad_sys;
            cp_rdata        <= dbg_rd ? dbg_rdata : ((sys_ok & to_core) ? sysctl_rdata : 32'h0);
            sysctl_sel      <= sys_ok ? sys_hit : 5'h00;
            sysctl_wr       <= sys_ok & from_core;
            sysctl_wdata    <= cp_req.wdata;
            dbg_entry       <= entry_next;
            abort_suppress  <= abort_in_dbg;
            trace_run       <= ten_reg & ge_reg & ~take;
            trace_fill_once <= tmode_reg;
            // each update on the cache target loads one locked handler word
            icache_load     <= upd_rise & (tgt == JT_ICACHE);
            icache_lock     <= upd_rise & (tgt == JT_ICACHE);
            icache_data     <= jshift_reg;
        end
    end
endmodule

// ---- shared/debug_unit_pkg.sv ----
// constants, encodings and carriers for the core debug control unit
package debug_unit_pkg;
    // ==========================================
    // coprocessor numbering
    localparam logic [3:0] COPRO_DEBUG  = 4'he;
    localparam logic [3:0] COPRO_SYSCTL = 4'hf;
    localparam logic [3:0] CRN_TX       = 4'h8;
    localparam logic [3:0] CRN_RX       = 4'h9;
    localparam logic [3:0] CRN_DCS      = 4'ha;
    localparam logic [3:0] CRN_TBUF     = 4'hb;
    localparam logic [3:0] CRN_CHK0     = 4'hc;
    localparam logic [3:0] CRN_CHK1     = 4'hd;
    localparam logic [3:0] CRN_LINK     = 4'he;
    localparam logic [3:0] CRN_BKPT     = 4'he;
    localparam logic [3:0] CRM_IBKPT0   = 4'h8;
    localparam logic [3:0] CRM_IBKPT1   = 4'h9;
    localparam logic [3:0] CRM_DBKPT0   = 4'h0;
    localparam logic [3:0] CRM_DBKPT1   = 4'h3;
    localparam logic [3:0] CRM_DBKCTL   = 4'h4;
    // ==========================================
    // processor modes
    localparam logic [4:0] MODE_USER    = 5'h10;
    localparam logic [4:0] MODE_ABORT   = 5'h17;
    localparam logic [4:0] MODE_DEBUG   = 5'h15;
    // ==========================================
    // debug_ctl_stat layout
    localparam int GE_POS      = 31;
    localparam int HALT_POS    = 30;
    localparam int SA_POS      = 5;
    localparam int CAUSE_LSB   = 2;
    localparam int TMODE_POS   = 1;
    localparam int TEN_POS     = 0;
    localparam int LINK_RXF    = 31;
    localparam int LINK_TXF    = 28;
    localparam logic [6:0] TRAPS_RESET = 7'h00;
    localparam logic [2:0] CAUSE_RESET = 3'h0;
    localparam logic [2:0] CAUSE_IBKPT = 3'h1;
    localparam logic [2:0] CAUSE_DBKPT = 3'h2;
    localparam logic [2:0] CAUSE_BKPT  = 3'h3;
    localparam logic [2:0] CAUSE_EXT   = 3'h4;
    localparam logic [2:0] CAUSE_VTRAP = 3'h5;
    localparam logic [2:0] CAUSE_TFULL = 3'h6;
    // ==========================================
    // types
    typedef enum logic [2:0] {
        CP_READ  = 3'b000,
        CP_WRITE = 3'b001,
        CP_LOAD  = 3'b010,
        CP_STORE = 3'b011,
        CP_OP    = 3'b100
    } cp_kind_type;
    typedef enum logic [1:0] {
        JT_DCS    = 2'b00,
        JT_TX     = 2'b01,
        JT_RX     = 2'b10,
        JT_ICACHE = 2'b11
    } jtag_target_type;
    typedef enum logic [1:0] {
        VEC_RESET  = 2'b00,
        VEC_PABORT = 2'b01,
        VEC_DABORT = 2'b10
    } vector_sel_type;
    typedef struct packed {
        logic        valid;
        cp_kind_type kind;
        logic [3:0]  copro;
        logic [3:0]  primary_reg_num;
        logic [3:0]  secondary_reg_num;
        logic [2:0]  op1;
        logic [2:0]  op2;
        logic [4:0]  mode;
        logic [31:0] wdata;
    } cp_req_type;
    // vector_hit order: reset, undef, swi, pabort, dabort, irq, fiq
    typedef struct packed {
        logic       inst_bkpt;
        logic       data_bkpt;
        logic       bkpt_instr;
        logic       ext_break;
        logic       trace_full;
        logic [6:0] vector_hit;
        logic       data_abort;
        logic       special_state;
    } dbg_event_type;
    typedef struct packed {
        logic           take;
        vector_sel_type vector;
        logic [4:0]     mode;
        logic [2:0]     cause;
    } dbg_entry_type;
endpackage

// ---- verif/core_debug_control_unit_chk.sv ----
// concurrent checks on the core debug control unit ports
`timescale 1ns/1ps
module core_debug_control_unit_chk
(
    input wire logic                          clk,
    input wire logic                          nrst,
    input wire debug_unit_pkg::cp_req_type    cp_req,
    input wire logic                          cp_done,
    input wire logic                          cp_undef,
    input wire logic [31:0]                   cp_rdata,
    input wire logic [4:0]                    sysctl_sel,
    input wire logic                          sysctl_wr,
    input wire logic [31:0]                   sysctl_wdata,
    input wire debug_unit_pkg::dbg_event_type dbg_event,
    input wire debug_unit_pkg::dbg_entry_type dbg_entry,
    input wire logic                          abort_suppress,
    input wire logic                          trace_run
);
    import debug_unit_pkg::*;
    // ==========================================
    // request decode
    wire logic debug_copro  = cp_req.valid && cp_req.copro == COPRO_DEBUG;
    wire logic bkpt  = cp_req.valid && cp_req.copro == COPRO_SYSCTL && cp_req.primary_reg_num == CRN_BKPT;
    wire logic clean = cp_req.mode != MODE_USER && cp_req.op1 == 3'h0 && cp_req.op2 == 3'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_user_req;
        (debug_copro || bkpt) && cp_req.mode == MODE_USER;
    endsequence
    sequence s_trap_ack;
        cp_done && cp_undef;
    endsequence
    sequence s_dbkpt_only;
        dbg_event.data_bkpt && dbg_event.vector_hit == 7'h00;
    endsequence
    // ==========================================
    // properties
    a_user_undef: assert property (s_user_req |=> s_trap_ack)
        else $error("user access not trapped");
    a_op_undef: assert property (debug_copro && cp_req.kind == CP_OP |=> s_trap_ack)
        else $error("data operation not trapped");
    a_undef_done: assert property (cp_undef |-> cp_done)
        else $error("undef without done");
    a_debug_copro_answer: assert property (debug_copro |=> cp_done)
        else $error("debug coprocessor request unanswered");
    a_bkpt_select: assert property (
        bkpt && clean && cp_req.kind == CP_WRITE && cp_req.secondary_reg_num == CRM_DBKCTL
        |=> sysctl_wr && sysctl_sel == 5'h10 && sysctl_wdata == $past(cp_req.wdata))
        else $error("breakpoint control write misrouted");
    a_rdata_clear: assert property (
        cp_done && $past(cp_req.kind) != CP_READ && $past(cp_req.kind) != CP_STORE
        |-> cp_rdata == 32'h0)
        else $error("read data on a non-read");
    a_entry_route: assert property (dbg_entry.take |->
        (dbg_entry.mode == MODE_DEBUG && dbg_entry.vector == VEC_RESET) ||
        (dbg_entry.mode == MODE_ABORT && dbg_entry.vector ==
        (dbg_entry.cause == CAUSE_DBKPT ? VEC_DABORT : VEC_PABORT)))
        else $error("debug entry mode or vector wrong");
    a_dbkpt_cause: assert property (
        s_dbkpt_only ##1 dbg_entry.take |-> dbg_entry.cause == CAUSE_DBKPT)
        else $error("data breakpoint cause wrong");
    a_trace_stop: assert property (dbg_entry.take |-> !trace_run ##1 !trace_run)
        else $error("trace kept running after entry");
    a_abort_swallow: assert property (
        dbg_event.data_abort && dbg_event.special_state |=> abort_suppress)
        else $error("special state abort not swallowed");
endmodule
bind core_debug_control_unit core_debug_control_unit_chk u_core_debug_control_unit_chk
(
    .clk, .nrst, .cp_req, .cp_done, .cp_undef, .cp_rdata, .sysctl_sel, .sysctl_wr,
    .sysctl_wdata, .dbg_event, .dbg_entry, .abort_suppress, .trace_run
);

// ---- verif/jtag_debugger_model.sv ----
// behavioural external debugger driving the scan pins
`timescale 1ns/1ps
module jtag_debugger_model
(
    output logic       tck,
    output logic       trst_n,
    output logic       tdi,
    output logic       jtag_capture,
    output logic       jtag_shift,
    output logic       jtag_update,
    output logic [1:0] jtag_target,
    input  wire logic  tdo
);
    import debug_unit_pkg::*;
    localparam int HALF = 40;
    initial
    begin
        {tck, tdi, jtag_capture, jtag_shift, jtag_update} = 5'h0;
        trst_n = 1'b1;
        jtag_target = JT_DCS;
    end
    // low for eight core cycles, well over the two the sync needs
    task automatic test_reset();
        #3 trst_n = 1'b0;
        #(2 * HALF) trst_n = 1'b1;
    endtask
    // tck stands still low outside a frame; tdi flips after release so no stale bit lingers
    task automatic scan(input jtag_target_type tgt, input logic [31:0] din,
                        output logic [31:0] dout);
        #3 jtag_target = tgt;
        jtag_capture = 1'b1;
        #(2 * HALF) jtag_capture = 1'b0;
        jtag_shift = 1'b1;
        for (int k = 0; k < 32; k++)
        begin
            tdi = din[k];
            #HALF dout[k] = tdo;
            tck = 1'b1;
            #HALF tck = 1'b0;
        end
        jtag_shift = 1'b0;
        tdi = ~tdi;
        jtag_update = 1'b1;
        #(2 * HALF) jtag_update = 1'b0;
        #(2 * HALF);
    endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the core debug control unit
`timescale 1ns/1ps
module tb;
    import debug_unit_pkg::*;
    localparam logic [4:0]  MODE_SVC = 5'h13;
    localparam logic [13:0] E_IB = 14'h2000, E_DB = 14'h1000, E_BK = 14'h0800;
    localparam logic [13:0] E_EX = 14'h0400, E_TF = 14'h0200, V_FIQ = 14'h0100;
    logic          clk, nrst, cp_done, cp_undef, sysctl_wr, abort_suppress, trace_run;
    logic          trace_fill_once, tck, trst_n, tdi, jtag_capture, jtag_shift, jtag_update;
    logic          tdo, icache_load, icache_lock;
    logic [31:0]   sysctl_rdata, cp_rdata, sysctl_wdata, icache_data, ic_seen, jd;
    logic [4:0]    sysctl_sel;
    logic [1:0]    jtag_target;
    cp_req_type    cp_req;
    dbg_event_type dbg_event;
    dbg_entry_type dbg_entry;
    int            n_errors, cmp_count;
    core_debug_control_unit u_core_debug_control_unit (.clk, .nrst, .cp_req, .sysctl_rdata,
        .cp_done, .cp_undef, .cp_rdata, .sysctl_sel, .sysctl_wr, .sysctl_wdata, .dbg_event,
        .dbg_entry, .abort_suppress, .trace_run, .trace_fill_once, .tck, .trst_n, .tdi,
        .jtag_capture, .jtag_shift, .jtag_update, .jtag_target, .tdo, .icache_load,
        .icache_lock, .icache_data);
    jtag_debugger_model u_jtag_debugger_model (.tck, .trst_n, .tdi, .jtag_capture,
        .jtag_shift, .jtag_update, .jtag_target, .tdo);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (icache_load === 1'b1 && icache_lock === 1'b1) ic_seen <= icache_data;
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cp(input cp_kind_type k, input logic [3:0] co, primary_reg_num, secondary_reg_num,
                      input logic [2:0] op1, input logic [4:0] md, input logic [31:0] wd);
        @(posedge clk);
        cp_req <= '{1'b1, k, co, primary_reg_num, secondary_reg_num, op1, 3'h0, md, wd};
        @(posedge clk);
        cp_req.valid <= 1'b0;
        #1;
    endtask
    task automatic dwr(input logic [3:0] primary_reg_num, input logic [31:0] wd);
        cp(CP_WRITE, COPRO_DEBUG, primary_reg_num, 4'h0, 3'h0, MODE_SVC, wd);
    endtask
    task automatic drd(input logic [3:0] primary_reg_num, input logic [31:0] exp);
        cp(CP_READ, COPRO_DEBUG, primary_reg_num, 4'h0, 3'h0, MODE_SVC, 32'h0);
        check(cp_rdata, exp);
    endtask
    task automatic jw(input jtag_target_type t, input logic [31:0] din);
        u_jtag_debugger_model.scan(t, din, jd);
    endtask
    // expected entry image: take, vector, mode, cause
    task automatic ev(input logic [13:0] e, input logic [10:0] exp);
        @(posedge clk);
        dbg_event <= dbg_event_type'(e);
        @(posedge clk);
        dbg_event <= '0;
        #1;
        check({31'h0, dbg_entry.take}, {31'h0, exp[10]});
        if (exp[10])
            check({21'h0, dbg_entry}, {21'h0, exp});
    endtask
    // ==========================================
    // scenarios
    task automatic t_access();
        drd(CRN_DCS, 32'h0);
        dwr(CRN_DCS, 32'hffff_ffff);
        drd(CRN_DCS, 32'h8000_003f);
        check({31'h0, trace_run}, 32'h1);
        check({31'h0, trace_fill_once}, 32'h1);
        dwr(CRN_DCS, 32'h8000_0000);
        jw(JT_DCS, 32'h40df_0000);
        check(jd, 32'h8000_0000);
        drd(CRN_DCS, 32'hc0df_0000);
    endtask
    task automatic t_halt();
        ev(V_FIQ, {1'b1, VEC_RESET, MODE_DEBUG, CAUSE_VTRAP});
        ev(V_FIQ | E_DB | E_EX, {1'b1, VEC_RESET, MODE_DEBUG, CAUSE_VTRAP});
        ev(E_EX | E_TF, {1'b1, VEC_RESET, MODE_DEBUG, CAUSE_EXT});
        ev(E_IB | E_BK, {1'b1, VEC_RESET, MODE_DEBUG, CAUSE_IBKPT});
        ev(E_BK, {1'b1, VEC_RESET, MODE_DEBUG, CAUSE_BKPT});
        ev(14'h0003, 11'h0);
        check({31'h0, abort_suppress}, 32'h1);
        drd(CRN_DCS, 32'hc0df_002c);
    endtask
    task automatic t_monitor();
        jw(JT_DCS, 32'h0080_0000);
        ev(E_DB, {1'b1, VEC_DABORT, MODE_ABORT, CAUSE_DBKPT});
        ev(E_IB, {1'b1, VEC_PABORT, MODE_ABORT, CAUSE_IBKPT});
        ev(E_TF, {1'b1, VEC_PABORT, MODE_ABORT, CAUSE_TFULL});
        ev(14'h0080, 11'h0);
        dwr(CRN_DCS, 32'h8000_0001);
        @(posedge clk);
        #1 check({31'h0, trace_run}, 32'h1);
        ev(E_BK, {1'b1, VEC_PABORT, MODE_ABORT, CAUSE_BKPT});
        drd(CRN_DCS, 32'h8080_000c);
    endtask
    task automatic t_global_off();
        dwr(CRN_DCS, 32'h0);
        ev(E_BK | E_EX | E_IB | E_DB, 11'h0);
        ev(V_FIQ, 11'h0);
        jw(JT_DCS, 32'h4001_0000);
        ev(14'h0004, {1'b1, VEC_RESET, MODE_DEBUG, CAUSE_VTRAP});
    endtask
    task automatic t_decode();
        logic [3:0] crms [5] = '{CRM_IBKPT0, CRM_IBKPT1, CRM_DBKPT0, CRM_DBKPT1, CRM_DBKCTL};
        cp(CP_READ, COPRO_DEBUG, CRN_DCS, 4'h0, 3'h0, MODE_USER, 32'h0);
        check({cp_done, cp_undef}, 2'b11);
        cp(CP_OP, COPRO_DEBUG, CRN_TX, 4'h0, 3'h0, MODE_SVC, 32'h0);
        check({cp_done, cp_undef}, 2'b11);
        cp(CP_WRITE, COPRO_SYSCTL, CRN_BKPT, CRM_IBKPT0, 3'h1, MODE_SVC, 32'h0);
        check({cp_done, cp_undef}, 2'b11);
        cp(CP_READ, COPRO_DEBUG, CRN_DCS, 4'h1, 3'h0, MODE_SVC, 32'h0);
        check({cp_done, cp_undef}, 2'b10);
        check(cp_rdata, 32'h0);
        cp(CP_LOAD, COPRO_DEBUG, CRN_CHK0, 4'h0, 3'h0, MODE_SVC, 32'h0);
        check({cp_done, cp_undef}, 2'b10);
        cp(CP_STORE, COPRO_DEBUG, CRN_CHK1, 4'h0, 3'h0, MODE_SVC, 32'h0);
        check({cp_done, cp_undef}, 2'b10);
        for (int k = 0; k < 5; k++)
        begin
            cp(CP_WRITE, COPRO_SYSCTL, CRN_BKPT, crms[k], 3'h0, MODE_SVC, 32'h100 + k);
            check({sysctl_wr, sysctl_sel}, {1'b1, 5'(1 << k)});
            check(sysctl_wdata, 32'h100 + k);
            cp(CP_READ, COPRO_SYSCTL, CRN_BKPT, crms[k], 3'h0, MODE_SVC, 32'h0);
            check(cp_rdata, sysctl_rdata);
        end
    endtask
    task automatic t_link();
        dwr(CRN_TX, 32'h1234_5678);
        drd(CRN_LINK, 32'h1000_0000);
        jw(JT_TX, 32'h0);
        check(jd, 32'h1234_5678);
        drd(CRN_LINK, 32'h0);
        jw(JT_RX, 32'hcafe_0001);
        drd(CRN_LINK, 32'h8000_0000);
        drd(CRN_RX, 32'hcafe_0001);
        drd(CRN_LINK, 32'h0);
        jw(JT_ICACHE, 32'h0bad_f00d);
        check(ic_seen, 32'h0bad_f00d);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        {nrst, n_errors, cmp_count, ic_seen} = '0;
        cp_req = '0;
        dbg_event = '0;
        sysctl_rdata = 32'h5a5a_0f0f;
        u_jtag_debugger_model.test_reset();
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        t_access();
        t_halt();
        t_monitor();
        t_global_off();
        t_decode();
        t_link();
        end_of_test();
    end
    initial
    begin
        #500_000;
        n_errors++;
        end_of_test();
    end
endmodule
